// ---- include/ccm_pkg.sv ----
package ccm_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONV_COMMAND = 8'h00;
    localparam logic [7:0] OFF_CONV_MODE = 8'h04;
    localparam logic [7:0] OFF_ORDER_LOW = 8'h08;
    localparam logic [7:0] OFF_ORDER_HIGH = 8'h0c;
    localparam logic [7:0] OFF_CHAN_ON = 8'h10;
    localparam logic [7:0] OFF_CHAN_OFF = 8'h14;
    localparam logic [7:0] OFF_CHAN_STATE = 8'h18;
    localparam logic [7:0] OFF_LATEST = 8'h20;
    localparam logic [7:0] OFF_IRQ_ON = 8'h24;
    localparam logic [7:0] OFF_IRQ_OFF = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFF_OVERRUN = 8'h3c;
    localparam logic [7:0] OFF_EXT_MODE = 8'h40;
    localparam logic [7:0] OFF_CMP_WINDOW = 8'h44;
    localparam logic [7:0] OFF_CH0_RESULT = 8'h50;
    localparam logic [7:0] OFF_CH11_RESULT = 8'h78;
    localparam logic [7:0] OFF_ANALOG = 8'h94;
    localparam logic [7:0] OFF_TOUCH_MODE = 8'hb0;
    localparam logic [7:0] OFF_TOUCH_X = 8'hb4;
    localparam logic [7:0] OFF_TOUCH_Y = 8'hb8;
    localparam logic [7:0] OFF_TOUCH_F = 8'hbc;
    localparam logic [7:0] OFF_TRIGGER = 8'hc0;
    localparam logic [7:0] OFF_LOCK_MODE = 8'he4;
    localparam logic [7:0] OFF_LOCK_STATUS = 8'he8;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CMD_SOFT_RESET_BIT = 0;
    localparam int CMD_START_BIT = 1;
    localparam int CMD_CALIB_BIT = 2;
    localparam int MODE_RES_BIT = 4;
    localparam int MODE_SLEEP_BIT = 5;
    localparam int MODE_FAST_WAKEUP_SELECT_BIT = 6;
    localparam int MODE_DIV_LSB = 8;
    localparam int MODE_DELAY_LSB = 16;
    localparam int MODE_TRACK_LSB = 24;
    localparam int MODE_USER_ORDER_ENABLE_BIT = 31;
    localparam logic [31:0] MODE_FIELD_MASK = 32'h8f0f_ff70;
    localparam logic [31:0] CHAN_MASK = 32'h0000_0fff;
    // status bits: 0 conversion done, 1 calibration done, 2 lock violation
    localparam int IRQ_BITS = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_CALIB_BIT = 1;
    localparam int IRQ_VIOL_BIT = 2;
    localparam logic [23:0] UNLOCK_KEY_VALUE = 24'h5ac3a5; // access key, arbitrary value
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_ANALOG = 32'h0000_0100;
    // ------------------------------------------------------------
    // timing: conversion clock periods per conversion (arbitrary core model)
    // ------------------------------------------------------------
    localparam logic [7:0] CONV_PERIODS_10 = 8'h0a;
    localparam logic [7:0] CONV_PERIODS_8 = 8'h08;

    typedef enum {ST_IDLE, ST_WAKE, ST_TRACK, ST_CONV} ccm_phase_type;

    // bus request carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ccm_bus_type;

    // timing captured at sequence start
    typedef struct packed {
        logic [7:0] div;
        logic [3:0] delay;
        logic [3:0] track;
        logic low_res;
    } ccm_timing_type;
endpackage

// ---- src/ccm_top.sv ----
`timescale 1ns/10ps
// Functional notes
// - command bit 0 resets whole block
// - command bit 1 starts conversion
// - calibration runs next or second sequence
// - calibration never updates latest result
// - mode writes blocked while locked
// - bit 4 selects 10 or 8 bits
// - sleep bit without fast wakeup powers core, reference off
// - fast wakeup keeps reference, core off
// - conv clock equals master over 2(div+1)
// - delay code selects start-up wait
// - tracking lasts field plus one periods
// - unmapped offsets are reserved, read zero
// - user order bit selects sequence order
// - locked write flags violation and source
// - correct key clears violation flag
module ccm_top #(
    parameter int NUM_CHAN = 12
) (
    input wire logic clk_sys, // master clock 40 MHz
    input wire logic resetn, // async reset, active low
    input wire logic [7:0] bus_addr, // register byte address
    input wire logic [31:0] bus_wdata, // write data
    input wire logic bus_wr, // write strobe
    input wire logic bus_rd, // read strobe
    input wire logic [9:0] core_result, // sample from analog core
    output logic [31:0] bus_rdata, // read data, cycle after strobe
    output logic irq, // level interrupt
    output logic core_power, // analog core powered
    output logic ref_power, // reference powered
    output logic core_sample, // tracking phase active
    output logic conv_clk_en, // conversion clock enable pulse
    output logic seq_busy // sequence in progress
);
    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r; // two-stage release
    logic rst_n; // synchronised reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] mode;
        logic [31:0] order_lo;
        logic [31:0] order_hi;
        logic [11:0] chan_on;
        logic [15:0] latest;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] ext_mode;
        logic [31:0] cmp_win;
        logic [31:0] analog;
        logic [31:0] touch;
        logic [31:0] trigger;
        logic lock_en;
        logic viol;
        logic [7:0] viol_src;
        logic [31:0] rdata;
        logic [8:0] div_cnt;
        logic [9:0] wait_cnt;
        ccm_pkg::ccm_phase_type phase;
        ccm_pkg::ccm_timing_type tim;
        logic [3:0] chan;
        logic [4:0] slot;
        logic calib_pend;
        logic [1:0] calib_wait;
        logic calib_run;
        logic start_pend;
    } ccm_state_type;

    ccm_state_type st_r; // registered state
    ccm_state_type st_nxt; // next state
    ccm_pkg::ccm_bus_type bus; // bundled request
    logic soft_rst; // soft reset pulse, combinational
    logic [9:0] delay_periods; // decoded start-up wait

    assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
    assign soft_rst = bus.wr && bus.addr == ccm_pkg::OFF_CONV_COMMAND
        && bus.wdata[ccm_pkg::CMD_SOFT_RESET_BIT];

    // ------------------------------------------------------------
    // start-up code decode
    // ------------------------------------------------------------
    always_comb begin
        case (st_r.tim.delay)
            4'h0: delay_periods = 10'd0;
            4'h1: delay_periods = 10'd8;
            4'h2: delay_periods = 10'd16;
            4'h3: delay_periods = 10'd24;
            4'h4: delay_periods = 10'd64;
            4'h5: delay_periods = 10'd80;
            4'h6: delay_periods = 10'd96;
            4'h7: delay_periods = 10'd112;
            // upper codes: 512 plus 64 per step
            default: delay_periods = {1'b1, st_r.tim.delay[2:0], 6'h00};
        endcase
    end

    // channel of the current slot in plain or user order
    function automatic logic [3:0] pick_chan(input logic [4:0] slot,
                                             input logic [63:0] order,
                                             input logic use_order);
        logic [3:0] idx;
        idx = slot[3:0];
        if (use_order) begin
            pick_chan = order[idx*4 +: 4];
        end else begin
            pick_chan = idx;
        end
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic prot_hit;
        logic wr_ok;
        logic conv_tick;
        logic [4:0] nslot;
        logic [3:0] ch;
        logic done_ev;
        logic calib_ev;
        logic viol_ev;
        st_nxt = st_r;
        st_nxt.rdata = '0;
        done_ev = 1'b0;
        calib_ev = 1'b0;
        viol_ev = 1'b0;
        ch = 4'h0;
        nslot = 5'h00;
        prot_hit = 1'b0;
        wr_ok = 1'b0;
        conv_tick = 1'b0;
        // protected register set
        prot_hit = bus.addr == ccm_pkg::OFF_CONV_MODE || bus.addr == ccm_pkg::OFF_ORDER_LOW
            || bus.addr == ccm_pkg::OFF_ORDER_HIGH || bus.addr == ccm_pkg::OFF_CHAN_ON
            || bus.addr == ccm_pkg::OFF_CHAN_OFF || bus.addr == ccm_pkg::OFF_EXT_MODE
            || bus.addr == ccm_pkg::OFF_CMP_WINDOW || bus.addr == ccm_pkg::OFF_ANALOG
            || bus.addr == ccm_pkg::OFF_TOUCH_MODE || bus.addr == ccm_pkg::OFF_TRIGGER;
        wr_ok = bus.wr && !(prot_hit && st_r.lock_en);
        // divider: one enable per conversion period of 2(div+1) master cycles,
        // so start-up and tracking counts are in whole conversion clock periods
        conv_tick = st_r.div_cnt == {st_r.tim.div, 1'b1};
        st_nxt.div_cnt = conv_tick ? 9'h000 : st_r.div_cnt + 9'h001;

        // register writes
        if (bus.wr && prot_hit && st_r.lock_en) begin
            viol_ev = 1'b1;
            st_nxt.viol = 1'b1;
            st_nxt.viol_src = bus.addr;
        end
        if (wr_ok) begin
            case (bus.addr)
                ccm_pkg::OFF_CONV_COMMAND: begin
                    if (bus.wdata[ccm_pkg::CMD_START_BIT]) begin
                        st_nxt.start_pend = 1'b1;
                    end
                    if (bus.wdata[ccm_pkg::CMD_CALIB_BIT]) begin
                        st_nxt.calib_pend = 1'b1;
                        st_nxt.calib_wait = (st_r.phase == ccm_pkg::ST_IDLE) ? 2'd2 : 2'd1;
                    end
                end
                ccm_pkg::OFF_CONV_MODE: st_nxt.mode = bus.wdata & ccm_pkg::MODE_FIELD_MASK;
                ccm_pkg::OFF_ORDER_LOW: st_nxt.order_lo = bus.wdata;
                ccm_pkg::OFF_ORDER_HIGH: st_nxt.order_hi = bus.wdata;
                ccm_pkg::OFF_CHAN_ON: st_nxt.chan_on = st_r.chan_on | bus.wdata[11:0];
                ccm_pkg::OFF_CHAN_OFF: st_nxt.chan_on = st_r.chan_on & ~bus.wdata[11:0];
                ccm_pkg::OFF_IRQ_ON: st_nxt.irq_mask = st_r.irq_mask | bus.wdata[2:0];
                ccm_pkg::OFF_IRQ_OFF: st_nxt.irq_mask = st_r.irq_mask & ~bus.wdata[2:0];
                ccm_pkg::OFF_IRQ_STATUS: st_nxt.irq_stat = st_r.irq_stat & ~bus.wdata[2:0];
                ccm_pkg::OFF_EXT_MODE: st_nxt.ext_mode = bus.wdata;
                ccm_pkg::OFF_CMP_WINDOW: st_nxt.cmp_win = bus.wdata;
                ccm_pkg::OFF_ANALOG: st_nxt.analog = bus.wdata;
                ccm_pkg::OFF_TOUCH_MODE: st_nxt.touch = bus.wdata;
                ccm_pkg::OFF_TRIGGER: st_nxt.trigger = bus.wdata;
                ccm_pkg::OFF_LOCK_MODE: begin
                    if (bus.wdata[31:8] == ccm_pkg::UNLOCK_KEY_VALUE) begin
                        st_nxt.lock_en = bus.wdata[0];
                        st_nxt.viol = viol_ev;
                    end
                end
                default: ; // reserved offsets ignored
            endcase
        end

        // sequencer, stepping on conversion clock enables
        case (st_r.phase)
            ccm_pkg::ST_IDLE: begin
                if (st_r.start_pend) begin
                    st_nxt.start_pend = 1'b0;
                    // latch timing for this whole sequence
                    st_nxt.tim.div = st_r.mode[ccm_pkg::MODE_DIV_LSB +: 8];
                    st_nxt.tim.delay = st_r.mode[ccm_pkg::MODE_DELAY_LSB +: 4];
                    st_nxt.tim.track = st_r.mode[ccm_pkg::MODE_TRACK_LSB +: 4];
                    st_nxt.tim.low_res = st_r.mode[ccm_pkg::MODE_RES_BIT];
                    st_nxt.div_cnt = 9'h000;
                    st_nxt.slot = 5'h00;
                    st_nxt.wait_cnt = 10'd0;
                    st_nxt.calib_run = st_r.calib_pend && st_r.calib_wait == 2'd1;
                    if (st_r.calib_pend && st_r.calib_wait != 2'd1) begin
                        st_nxt.calib_wait = st_r.calib_wait - 2'd1;
                    end
                    if (st_r.calib_pend && st_r.calib_wait == 2'd1) begin
                        st_nxt.calib_pend = 1'b0;
                    end
                    st_nxt.phase = ccm_pkg::ST_WAKE;
                end
            end
            ccm_pkg::ST_WAKE: begin
                if (st_r.wait_cnt >= delay_periods) begin
                    st_nxt.wait_cnt = 10'd0;
                    st_nxt.phase = ccm_pkg::ST_TRACK;
                end else if (conv_tick) begin
                    st_nxt.wait_cnt = st_r.wait_cnt + 10'd1;
                end
            end
            ccm_pkg::ST_TRACK: begin
                if (conv_tick) begin
                    if (st_r.wait_cnt[3:0] == st_r.tim.track) begin
                        st_nxt.wait_cnt = 10'd0;
                        st_nxt.phase = ccm_pkg::ST_CONV;
                    end else begin
                        st_nxt.wait_cnt = st_r.wait_cnt + 10'd1;
                    end
                end
            end
            ccm_pkg::ST_CONV: begin
                if (conv_tick) begin
                    if (st_r.wait_cnt[7:0] == (st_r.tim.low_res ? ccm_pkg::CONV_PERIODS_8
                                               : ccm_pkg::CONV_PERIODS_10) - 8'h01) begin
                        ch = pick_chan(st_r.slot, {st_r.order_hi, st_r.order_lo},
                                       st_r.mode[ccm_pkg::MODE_USER_ORDER_ENABLE_BIT]);
                        if (!st_r.calib_run && st_r.chan_on[st_r.slot[3:0]]) begin
                            // 8-bit mode keeps the top bits of the sample
                            st_nxt.latest = {ch, 2'b00, st_r.tim.low_res
                                ? {2'b00, core_result[9:2]} : core_result};
                        end
                        nslot = st_r.slot + 5'h01;
                        st_nxt.wait_cnt = 10'd0;
                        if (nslot == 5'(NUM_CHAN)) begin
                            st_nxt.phase = ccm_pkg::ST_IDLE;
                            done_ev = !st_r.calib_run;
                            calib_ev = st_r.calib_run;
                            st_nxt.calib_run = 1'b0;
                        end else begin
                            st_nxt.slot = nslot;
                            st_nxt.phase = ccm_pkg::ST_TRACK;
                        end
                    end else begin
                        st_nxt.wait_cnt = st_r.wait_cnt + 10'd1;
                    end
                end
            end
            default: st_nxt.phase = ccm_pkg::ST_IDLE;
        endcase

        // sticky status: set wins over clear
        st_nxt.irq_stat = st_nxt.irq_stat | {viol_ev, calib_ev, done_ev};

        // register reads, data one cycle later
        if (bus.rd) begin
            case (bus.addr)
                ccm_pkg::OFF_CONV_MODE: st_nxt.rdata = st_r.mode;
                ccm_pkg::OFF_ORDER_LOW: st_nxt.rdata = st_r.order_lo;
                ccm_pkg::OFF_ORDER_HIGH: st_nxt.rdata = st_r.order_hi;
                ccm_pkg::OFF_CHAN_STATE: st_nxt.rdata = {20'h00000, st_r.chan_on};
                ccm_pkg::OFF_LATEST: st_nxt.rdata = {16'h0000, st_r.latest};
                ccm_pkg::OFF_IRQ_MASK: st_nxt.rdata = {29'h0, st_r.irq_mask};
                ccm_pkg::OFF_IRQ_STATUS: st_nxt.rdata = {29'h0, st_r.irq_stat};
                ccm_pkg::OFF_EXT_MODE: st_nxt.rdata = st_r.ext_mode;
                ccm_pkg::OFF_CMP_WINDOW: st_nxt.rdata = st_r.cmp_win;
                ccm_pkg::OFF_ANALOG: st_nxt.rdata = st_r.analog;
                ccm_pkg::OFF_TOUCH_MODE: st_nxt.rdata = st_r.touch;
                ccm_pkg::OFF_TRIGGER: st_nxt.rdata = st_r.trigger;
                ccm_pkg::OFF_LOCK_MODE: st_nxt.rdata = {31'h0, st_r.lock_en};
                ccm_pkg::OFF_LOCK_STATUS: st_nxt.rdata = {16'h0, st_r.viol_src, 7'h0, st_r.viol};
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register; soft reset acts like hardware reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.analog <= ccm_pkg::RST_ANALOG;
        end else if (soft_rst) begin
            st_r <= '0;
            st_r.analog <= ccm_pkg::RST_ANALOG;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic active; // core in use
    assign active = st_r.phase != ccm_pkg::ST_IDLE;
    assign bus_rdata = st_r.rdata;
    assign irq = |(st_r.irq_stat & st_r.irq_mask);
    assign core_power = active || !st_r.mode[ccm_pkg::MODE_SLEEP_BIT]
        && !st_r.mode[ccm_pkg::MODE_FAST_WAKEUP_SELECT_BIT];
    assign ref_power = active || !st_r.mode[ccm_pkg::MODE_SLEEP_BIT]
        || st_r.mode[ccm_pkg::MODE_FAST_WAKEUP_SELECT_BIT];
    assign core_sample = st_r.phase == ccm_pkg::ST_TRACK;
    assign conv_clk_en = active && st_r.div_cnt == {st_r.tim.div, 1'b1};
    assign seq_busy = active;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_locked_mode_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_wr && bus_addr == ccm_pkg::OFF_CONV_MODE && st_r.lock_en && !soft_rst
        |=> $stable(st_r.mode)) else $error("mode changed while locked");
    a_viol_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_wr && bus_addr == ccm_pkg::OFF_TRIGGER && st_r.lock_en && !soft_rst
        |=> st_r.viol && st_r.viol_src == ccm_pkg::OFF_TRIGGER) else $error("violation lost");
    a_key_clears_viol: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_wr && bus_addr == ccm_pkg::OFF_LOCK_MODE
        && bus_wdata[31:8] == ccm_pkg::UNLOCK_KEY_VALUE |=> !st_r.viol)
        else $error("key did not clear flag");
    a_soft_reset_all: assert property (@(posedge clk_sys) disable iff (!rst_n)
        soft_rst |=> st_r.mode == 32'h0 && !seq_busy) else $error("soft reset incomplete");
    a_start_begins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !seq_busy && st_r.start_pend && !soft_rst |=> seq_busy) else $error("start ignored");
    a_mode_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_r.mode & ~ccm_pkg::MODE_FIELD_MASK) == 32'h0) else $error("unused mode bits set");
    a_calib_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.calib_run && !soft_rst |=> $stable(st_r.latest)) else $error("calib wrote result");
    a_timing_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        seq_busy && $past(seq_busy) |-> $stable(st_r.tim)) else $error("timing changed mid run");
    a_fast_wakeup_select_ref_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.mode[ccm_pkg::MODE_FAST_WAKEUP_SELECT_BIT] && !seq_busy |-> ref_power && !core_power)
        else $error("fast wakeup power wrong");
    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_rd && bus_addr == 8'h1c |=> bus_rdata == 32'h0) else $error("reserved read nonzero");
    a_div_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
        conv_clk_en && st_r.tim.div == 8'h01 && st_r.phase == ccm_pkg::ST_TRACK
        |=> !conv_clk_en [*3] ##1 (conv_clk_en || !seq_busy)) else $error("tick spacing");
    a_calib_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.calib_run && !soft_rst ##1 !seq_busy |-> st_r.irq_stat[ccm_pkg::IRQ_CALIB_BIT])
        else $error("calib not flagged");
    a_sleep_both_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.mode[ccm_pkg::MODE_SLEEP_BIT] && !st_r.mode[ccm_pkg::MODE_FAST_WAKEUP_SELECT_BIT] && !seq_busy
        |-> !core_power && !ref_power) else $error("sleep power wrong");
    a_mode_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_wr && bus_addr == ccm_pkg::OFF_CONV_MODE && !st_r.lock_en && !soft_rst
        |=> st_r.mode == ($past(bus_wdata) & ccm_pkg::MODE_FIELD_MASK))
        else $error("mode write lost");
    c_user_order: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(seq_busy) && st_r.mode[ccm_pkg::MODE_USER_ORDER_ENABLE_BIT]);
    c_sequence_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(seq_busy));
    c_locked_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(st_r.viol));
    c_calib_run: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(st_r.calib_run));
endmodule

// ---- verif/ccm_top_tb.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// one compare: counts every check, reports mismatches at once
// ------------------------------------------------------------
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module ccm_top_tb;
    logic clk_sys = 1'b0; // master clock
    logic resetn = 1'b0; // async reset
    logic [7:0] bus_addr = 8'h00; // register address
    logic [31:0] bus_wdata = 32'h0000_0000; // write data
    logic bus_wr = 1'b0; // write strobe
    logic bus_rd = 1'b0; // read strobe
    logic [9:0] core_result = 10'h155; // core sample
    logic [31:0] bus_rdata; // read data
    logic irq, core_power, ref_power, core_sample, conv_clk_en, seq_busy; // status outputs
    logic [31:0] rd_val; // last read value
    int mismatches = 0; // failed compares
    int tests_run = 0; // compares made
    int gap; // cycles between enable pulses
    ccm_top i_ccm_top (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .core_result(core_result),
        .bus_rdata(bus_rdata), .irq(irq), .core_power(core_power), .ref_power(ref_power),
        .core_sample(core_sample), .conv_clk_en(conv_clk_en), .seq_busy(seq_busy));
    // 25 ns period
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // bus tasks and helpers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 rd_val = bus_rdata;
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // bounded wait on the busy level; a hang ends the run
    task automatic wait_busy(input logic v);
        int n;
        for (n = 0; n < 20000 && seq_busy !== v; n++) @(posedge clk_sys);
        if (seq_busy !== v) begin
            mismatches++;
            $display("BAD seq_busy wait exp %h got %h", v, seq_busy);
            end_sim();
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_map();
        rd(ccm_pkg::OFF_CONV_MODE); `CHK("mode reset", 32'h0000_0000, rd_val)
        rd(ccm_pkg::OFF_ANALOG); `CHK("analog reset", 32'h0000_0100, rd_val)
        rd(8'h1c); `CHK("reserved 1c", 32'h0000_0000, rd_val)
        wr(8'h38, 32'hffff_ffff);
        rd(8'h38); `CHK("reserved 38", 32'h0000_0000, rd_val)
        $display("test reset_map done");
    endtask
    task automatic t_mode_power();
        wr(ccm_pkg::OFF_CONV_MODE, 32'hffff_ffff);
        rd(ccm_pkg::OFF_CONV_MODE); `CHK("mode mask", 32'h8f0f_ff70, rd_val)
        wr(ccm_pkg::OFF_CONV_MODE, 32'h0000_0020);
        #1 `CHK("sleep core", 1'b0, core_power)
        `CHK("sleep ref", 1'b0, ref_power)
        wr(ccm_pkg::OFF_CONV_MODE, 32'h0000_0060);
        #1 `CHK("fast_wakeup_select core", 1'b0, core_power)
        `CHK("fast_wakeup_select ref", 1'b1, ref_power)
        $display("test mode_power done");
    endtask
    // locked write is dropped, flagged with its address, raises irq
    task automatic t_lock();
        wr(ccm_pkg::OFF_IRQ_ON, 32'h0000_0004);
        wr(ccm_pkg::OFF_LOCK_MODE, {ccm_pkg::UNLOCK_KEY_VALUE, 8'h01});
        wr(ccm_pkg::OFF_CONV_MODE, 32'h0000_0010);
        rd(ccm_pkg::OFF_CONV_MODE); `CHK("locked mode", 32'h0000_0060, rd_val)
        rd(ccm_pkg::OFF_LOCK_STATUS); `CHK("viol src", 32'h0000_0401, rd_val)
        `CHK("viol irq", 1'b1, irq)
        wr(ccm_pkg::OFF_TRIGGER, 32'h0000_0001);
        rd(ccm_pkg::OFF_LOCK_STATUS); `CHK("trig src", 32'h0000_c001, rd_val)
        wr(ccm_pkg::OFF_LOCK_MODE, {ccm_pkg::UNLOCK_KEY_VALUE, 8'h00});
        rd(ccm_pkg::OFF_LOCK_STATUS); `CHK("viol clr", 1'b0, rd_val[0])
        wr(ccm_pkg::OFF_IRQ_STATUS, 32'h0000_0004);
        #1 `CHK("irq clr", 1'b0, irq)
        wr(ccm_pkg::OFF_IRQ_OFF, 32'h0000_0004);
        $display("test lock done");
    endtask
    // one sequence on slot 0; divider 1 gives a pulse every 4 cycles
    task automatic t_conv(input logic [31:0] mode, input logic [31:0] exp);
        wr(ccm_pkg::OFF_CONV_MODE, mode);
        wr(ccm_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
        wr(ccm_pkg::OFF_CONV_COMMAND, 32'h0000_0002);
        wait_busy(1'b1);
        #1 `CHK("tracking", 1'b1, core_sample)
        for (gap = 0; gap < 50 && conv_clk_en !== 1'b1; gap++) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1;
        for (gap = 1; gap < 50 && conv_clk_en !== 1'b1; gap++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK("div gap", 4, gap)
        wait_busy(1'b0);
        #1 `CHK("done irq", 1'b1, irq)
        rd(ccm_pkg::OFF_LATEST); `CHK("latest", exp, rd_val)
        $display("test conv done");
    endtask
    // asked while idle: first sequence normal, second one calibrates
    task automatic t_calib();
        wr(ccm_pkg::OFF_CONV_COMMAND, 32'h0000_0004);
        wr(ccm_pkg::OFF_CONV_COMMAND, 32'h0000_0002);
        wait_busy(1'b1);
        wait_busy(1'b0);
        core_result <= 10'h2aa;
        #1 `CHK("first seq done", 1'b1, irq)
        wr(ccm_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
        wr(ccm_pkg::OFF_CONV_COMMAND, 32'h0000_0002);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(ccm_pkg::OFF_IRQ_STATUS); `CHK("calib status", 32'h0000_0002, rd_val)
        rd(ccm_pkg::OFF_LATEST); `CHK("calib keeps", 32'h0000_5155, rd_val)
        $display("test calib done");
    endtask
    task automatic t_soft_reset();
        wr(ccm_pkg::OFF_CONV_MODE, 32'h0000_0070);
        wr(ccm_pkg::OFF_CONV_COMMAND, 32'h0000_0001);
        rd(ccm_pkg::OFF_CONV_MODE); `CHK("soft_reset_cmd mode", 32'h0000_0000, rd_val)
        rd(ccm_pkg::OFF_IRQ_MASK); `CHK("soft_reset_cmd mask", 32'h0000_0000, rd_val)
        rd(ccm_pkg::OFF_LATEST); `CHK("soft_reset_cmd latest", 32'h0000_0000, rd_val)
        $display("test soft_reset done");
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset_map();
        t_mode_power();
        t_lock();
        wr(ccm_pkg::OFF_CHAN_ON, 32'h0000_0001);
        wr(ccm_pkg::OFF_IRQ_ON, 32'h0000_0001);
        t_conv(32'h0000_0100, 32'h0000_0155);
        t_conv(32'h0000_0110, 32'h0000_0055);
        wr(ccm_pkg::OFF_ORDER_LOW, 32'h0000_0005);
        t_conv(32'h8000_0100, 32'h0000_5155);
        t_calib();
        t_soft_reset();
        end_sim();
    end
endmodule
